//--- logic/irr_defines.svh
`ifndef IRR_DEFINES_SVH
`define IRR_DEFINES_SVH

// =====================================================================
// Constants for the interrupt request input routing block
`define IRR_CLK_FREQ_HZ     25000000
`define IRR_MASTER_FREQ_KHZ 28636
`define IRR_NUM_BUS_IRQ     11
`define IRR_SYNC_STAGES     2
// Bit positions in the bus request vector (IRQ3..7, 9..12, 14, 15)
`define IRR_BIT_IRQ3        0
`define IRR_BIT_IRQ4        1
// Routing select encodings for each serial source
`define IRR_ROUTE_LINE3     1'h0
`define IRR_ROUTE_LINE4     1'h1
// Local synchroniser group: pin positions
`define IRR_NUM_LOCAL_SYNC  7
`define IRR_LOC_KBD         0
`define IRR_LOC_AUX         1
`define IRR_LOC_RTC         2
`define IRR_LOC_SER_A       3
`define IRR_LOC_SER_B       4
`define IRR_LOC_EN_A_N      5
`define IRR_LOC_EN_B_N      6
// Local group reset levels: enables idle high (blocked)
`define IRR_LOCAL_IDLE      7'h60
// Local pending vector bit positions
`define IRR_PEND_KBD_AUX    0
`define IRR_PEND_RTC        1
`define IRR_PEND_SER_A      2
`define IRR_PEND_SER_B      3

`endif

//--- logic/irr_pkg.sv
// =====================================================================
// Shared types for the interrupt request input routing block
package irr_pkg;
    typedef logic [10:0] irr_bus_irq_t;
    typedef logic [3:0]  irr_local_irq_t;
endpackage

//--- logic/irr_link_if.sv
`include "irr_defines.svh"

// =====================================================================
// Link between the interrupting peripherals and the routing device
interface irr_link_if;
    logic        keyboard_irq;
    logic        aux_pointer_irq;
    logic        rtc_irq;
    logic        serial_irq_a;
    logic        serial_irq_b;
    logic        serial_irq_a_enable_n;
    logic        serial_irq_b_enable_n;
    logic [10:0] bus_irq;
    logic        cpu_irq;

    modport device (
        input  keyboard_irq, aux_pointer_irq, rtc_irq, serial_irq_a, serial_irq_b,
        input  serial_irq_a_enable_n, serial_irq_b_enable_n, bus_irq,
        output cpu_irq
    );
    modport system (
        output keyboard_irq, aux_pointer_irq, rtc_irq, serial_irq_a, serial_irq_b,
        output serial_irq_a_enable_n, serial_irq_b_enable_n, bus_irq,
        input  cpu_irq
    );
endinterface

//--- logic/irr_system_end.sv
`include "irr_defines.svh"

// =====================================================================
// System side: keyboard controller, clock module, serial ports, bus
module irr_system_end
    import irr_pkg::*;
(
    // Clock and reset
    input  wire logic         ref_clk_in,
    input  wire logic         rst_in,
    // Peripheral request sources
    input  wire logic         keyboard_irq_in,
    input  wire logic         aux_pointer_irq_in,
    input  wire logic         rtc_irq_in,
    input  wire logic         serial_irq_a_in,
    input  wire logic         serial_irq_b_in,
    input  wire logic         serial_a_allow_in,
    input  wire logic         serial_b_allow_in,
    input  wire irr_bus_irq_t bus_irq_in,
    // Processor view
    output logic              cpu_irq_seen_out,
    // Link
    irr_link_if.system        link
);

    // =================================================================
    // Drive link from registered copies of the sources
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            link.keyboard_irq    <= 1'h0;
            link.aux_pointer_irq <= 1'h0;
            link.rtc_irq         <= 1'h0;
            link.serial_irq_a    <= 1'h0;
            link.serial_irq_b    <= 1'h0;
            link.bus_irq         <= '0;
        end else begin
            link.keyboard_irq    <= keyboard_irq_in;
            link.aux_pointer_irq <= aux_pointer_irq_in;
            link.rtc_irq         <= rtc_irq_in;
            link.serial_irq_a    <= serial_irq_a_in;
            link.serial_irq_b    <= serial_irq_b_in;
            link.bus_irq         <= bus_irq_in;
        end
    end

    // Enables: pulled low to allow each serial source
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            link.serial_irq_a_enable_n <= 1'h1;
            link.serial_irq_b_enable_n <= 1'h1;
        end else begin
            link.serial_irq_a_enable_n <= ~serial_a_allow_in;
            link.serial_irq_b_enable_n <= ~serial_b_allow_in;
        end
    end

    // Processor interrupt pin capture
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            cpu_irq_seen_out <= 1'h0;
        end else begin
            cpu_irq_seen_out <= link.cpu_irq;
        end
    end

endmodule // irr_system_end

//--- logic/irr_device_end.sv
`include "irr_defines.svh"

// =====================================================================
// Device side: synchronise requests, route serial lines, drive CPU pin
// Contract
// - Route each serial input to line 3/4
// - Serial A passes only while enable low
// - Serial B passes only while enable low
// - Accept shared asynchronous bus request inputs
// - Drive CPU interrupt when enabled request pending
// - Keyboard controller drives keyboard, aux inputs
// - Clock module drives real-time-clock input
// - All logic runs from one master clock
module irr_device_end
    import irr_pkg::*;
#(
    parameter int NUM_BUS_IRQ = `IRR_NUM_BUS_IRQ
)
(
    // Clock and reset
    input  wire logic         ref_clk_in,
    input  wire logic         rst_in,
    // Routing and enable control
    input  wire logic         serial_a_route_in,
    input  wire logic         serial_b_route_in,
    input  wire irr_bus_irq_t bus_enable_in,
    input  wire irr_local_irq_t local_enable_in,
    // Status
    output irr_bus_irq_t      bus_pending_out,
    output irr_local_irq_t    local_pending_out,
    output logic              cpu_irq_out,
    // Link
    irr_link_if.device        link
);

    // =================================================================
    // Sizes and idle levels of the synchroniser groups
    localparam int                   NUM_LOCAL  = `IRR_NUM_LOCAL_SYNC;
    localparam logic [NUM_LOCAL-1:0] LOCAL_IDLE = `IRR_LOCAL_IDLE;

    // Latency from a link level to the registered outputs:
    // first stage, second stage, then the output flip-flops.
    // Enables reset to their blocked level so that no serial
    // source slips through while the chains refill.

    // =================================================================
    // Raw pin levels, gathered into one vector per group
    logic [NUM_BUS_IRQ-1:0] bus_raw;
    logic [NUM_LOCAL-1:0]   local_raw;

    // Shared bus lines, driven by several devices at once
    assign bus_raw = link.bus_irq;

    // Keyboard controller and clock module sources
    assign local_raw[`IRR_LOC_KBD] = link.keyboard_irq;
    assign local_raw[`IRR_LOC_AUX] = link.aux_pointer_irq;
    assign local_raw[`IRR_LOC_RTC] = link.rtc_irq;

    // Serial sources and their active-low enables
    assign local_raw[`IRR_LOC_SER_A]  = link.serial_irq_a;
    assign local_raw[`IRR_LOC_SER_B]  = link.serial_irq_b;
    assign local_raw[`IRR_LOC_EN_A_N] = link.serial_irq_a_enable_n;
    assign local_raw[`IRR_LOC_EN_B_N] = link.serial_irq_b_enable_n;

    // =================================================================
    // Two-stage synchronisers, all on the one clock
    logic [NUM_BUS_IRQ-1:0] bus_sync;
    logic [NUM_LOCAL-1:0]   local_sync;

    genvar bus_idx;
    genvar loc_idx;

    // One chain per shared bus line
    generate
        for (bus_idx = 0; bus_idx < NUM_BUS_IRQ; bus_idx++) begin : g_bus_sync
            logic meta_q;
            logic sync_q;

            // First stage catches the asynchronous level
            always_ff @(posedge ref_clk_in) begin
                if (rst_in) begin
                    meta_q <= 1'h0;
                end else begin
                    meta_q <= bus_raw[bus_idx];
                end
            end

            // Second stage is the only reader of the first
            always_ff @(posedge ref_clk_in) begin
                if (rst_in) begin
                    sync_q <= 1'h0;
                end else begin
                    sync_q <= meta_q;
                end
            end

            assign bus_sync[bus_idx] = sync_q;
        end
    endgenerate

    // One chain per local source or enable pin
    generate
        for (loc_idx = 0; loc_idx < NUM_LOCAL; loc_idx++) begin : g_local_sync
            logic meta_q;
            logic sync_q;

            // First stage catches the asynchronous level
            always_ff @(posedge ref_clk_in) begin
                if (rst_in) begin
                    meta_q <= LOCAL_IDLE[loc_idx];
                end else begin
                    meta_q <= local_raw[loc_idx];
                end
            end

            // Second stage is the only reader of the first
            always_ff @(posedge ref_clk_in) begin
                if (rst_in) begin
                    sync_q <= LOCAL_IDLE[loc_idx];
                end else begin
                    sync_q <= meta_q;
                end
            end

            assign local_sync[loc_idx] = sync_q;
        end
    endgenerate

    // =================================================================
    // Serial gating: a source passes only while its enable is low
    logic         serial_a_ok;
    logic         serial_b_ok;
    irr_bus_irq_t routed;

    assign serial_a_ok = local_sync[`IRR_LOC_SER_A] & ~local_sync[`IRR_LOC_EN_A_N];
    assign serial_b_ok = local_sync[`IRR_LOC_SER_B] & ~local_sync[`IRR_LOC_EN_B_N];

    // =================================================================
    // Serial sources OR onto lines 3 and 4 per select
    always_comb begin
        routed = bus_sync;
        if (serial_a_route_in == `IRR_ROUTE_LINE3) begin
            routed[`IRR_BIT_IRQ3] = routed[`IRR_BIT_IRQ3] | serial_a_ok;
        end else begin
            routed[`IRR_BIT_IRQ4] = routed[`IRR_BIT_IRQ4] | serial_a_ok;
        end
        if (serial_b_route_in == `IRR_ROUTE_LINE3) begin
            routed[`IRR_BIT_IRQ3] = routed[`IRR_BIT_IRQ3] | serial_b_ok;
        end else begin
            routed[`IRR_BIT_IRQ4] = routed[`IRR_BIT_IRQ4] | serial_b_ok;
        end
    end

    // =================================================================
    // Local pending levels; keyboard and auxiliary share one bit
    irr_local_irq_t local_now;

    assign local_now[`IRR_PEND_KBD_AUX] = local_sync[`IRR_LOC_KBD] | local_sync[`IRR_LOC_AUX];
    assign local_now[`IRR_PEND_RTC]     = local_sync[`IRR_LOC_RTC];
    assign local_now[`IRR_PEND_SER_A]   = serial_a_ok;
    assign local_now[`IRR_PEND_SER_B]   = serial_b_ok;

    // =================================================================
    // Enabled request detection; serial bits count through routing
    logic bus_hit;
    logic local_hit;
    logic irq_now;

    assign bus_hit   = |(routed & bus_enable_in);
    assign local_hit = (local_now[`IRR_PEND_KBD_AUX] & local_enable_in[`IRR_PEND_KBD_AUX])
                     | (local_now[`IRR_PEND_RTC] & local_enable_in[`IRR_PEND_RTC]);
    assign irq_now   = bus_hit | local_hit;

    // =================================================================
    // Registered outputs, one flip-flop group per concern

    // Routed bus pending levels
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            bus_pending_out <= '0;
        end else begin
            bus_pending_out <= routed;
        end
    end

    // Local pending levels
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            local_pending_out <= '0;
        end else begin
            local_pending_out <= local_now;
        end
    end

    // Processor interrupt status copy
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            cpu_irq_out <= 1'h0;
        end else begin
            cpu_irq_out <= irq_now;
        end
    end

    // Processor interrupt pin on the link
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            link.cpu_irq <= 1'h0;
        end else begin
            link.cpu_irq <= irq_now;
        end
    end

endmodule // irr_device_end

//--- tb/irr_link_monitor.sv
// =====================================================================
// Link checker: CPU request against link activity and reset
module irr_link_monitor (
    // Clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    // Link levels
    input  wire logic        keyboard_irq, aux_pointer_irq, rtc_irq,
    input  wire logic        serial_irq_a, serial_irq_b,
    input  wire logic        serial_irq_a_enable_n, serial_irq_b_enable_n,
    input  wire logic [10:0] bus_irq,
    input  wire logic        cpu_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic quiet;
    logic others_quiet_a;
    logic others_quiet_b;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    // No request source live on the link
    assign quiet = !(keyboard_irq | aux_pointer_irq | rtc_irq | (|bus_irq)
                   | (serial_irq_a & !serial_irq_a_enable_n) | (serial_irq_b & !serial_irq_b_enable_n));
    // Every source but one serial line quiet
    assign others_quiet_a = !(keyboard_irq | aux_pointer_irq | rtc_irq | (|bus_irq)
                            | (serial_irq_b & !serial_irq_b_enable_n));
    assign others_quiet_b = !(keyboard_irq | aux_pointer_irq | rtc_irq | (|bus_irq)
                            | (serial_irq_a & !serial_irq_a_enable_n));
    property p_quiet_low;
        $past(quiet, 3) |-> !cpu_irq;
    endproperty
    a_quiet_low: assert property (p_quiet_low) else $error("cpu request without a source");
    property p_rise_cause;
        $rose(cpu_irq) |-> !$past(quiet, 3);
    endproperty
    a_rise_cause: assert property (p_rise_cause) else $error("cpu request early");
    property p_serial_gate;
        $past(others_quiet_a && serial_irq_a_enable_n, 3) |-> !cpu_irq;
    endproperty
    a_serial_gate: assert property (p_serial_gate) else $error("blocked serial raised cpu");
    property p_serial_b_gate;
        $past(others_quiet_b && serial_irq_b_enable_n, 3) |-> !cpu_irq;
    endproperty
    a_serial_b_gate: assert property (p_serial_b_gate) else $error("blocked serial b raised cpu");
    property p_release_quiet;
        $fell(rst_in) |-> !cpu_irq [*3];
    endproperty
    a_release_quiet: assert property (p_release_quiet) else $error("cpu request too soon after reset");
    property p_reset_state;
        @(posedge ref_clk_in) disable iff (1'b0)
        rst_in |=> (serial_irq_a_enable_n && serial_irq_b_enable_n && !cpu_irq);
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
    // Main scenarios
    c_rise: cover property ($rose(cpu_irq));
    c_serial_on: cover property (serial_irq_a && !serial_irq_a_enable_n);
    c_serial_off: cover property (serial_irq_b && serial_irq_b_enable_n);
endmodule // irr_link_monitor

//--- tb/interrupt_request_input_routing_bench.sv
// =====================================================================
// Bench: system end and device end joined by the link
module interrupt_request_input_routing_bench
    import irr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic           ref_clk_in, rst_in, cpu, seen;
    logic [8:0]     c;
    irr_bus_irq_t   b, be, bp;
    irr_local_irq_t le, lp;
    int             num_errors, num_checks, n;
    irr_link_if irr_link_if_i ();
    irr_system_end irr_system_end_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .keyboard_irq_in(c[8]),
        .aux_pointer_irq_in(c[7]), .rtc_irq_in(c[6]), .serial_irq_a_in(c[5]), .serial_irq_b_in(c[4]),
        .serial_a_allow_in(c[3]), .serial_b_allow_in(c[2]), .bus_irq_in(b), .cpu_irq_seen_out(seen),
        .link(irr_link_if_i));
    irr_device_end irr_device_end_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .serial_a_route_in(c[1]),
        .serial_b_route_in(c[0]), .bus_enable_in(be), .local_enable_in(le), .bus_pending_out(bp),
        .local_pending_out(lp), .cpu_irq_out(cpu), .link(irr_link_if_i));
    irr_link_monitor irr_link_monitor_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .keyboard_irq(irr_link_if_i.keyboard_irq), .aux_pointer_irq(irr_link_if_i.aux_pointer_irq),
        .rtc_irq(irr_link_if_i.rtc_irq), .serial_irq_a(irr_link_if_i.serial_irq_a),
        .serial_irq_b(irr_link_if_i.serial_irq_b), .serial_irq_a_enable_n(irr_link_if_i.serial_irq_a_enable_n),
        .serial_irq_b_enable_n(irr_link_if_i.serial_irq_b_enable_n), .bus_irq(irr_link_if_i.bus_irq),
        .cpu_irq(irr_link_if_i.cpu_irq));
    // Clock, 40 ns period
    initial begin
        ref_clk_in = 1'b0;
        forever #20 ref_clk_in = ~ref_clk_in;
    end
    // Compare observed against expected
    task check(input logic [16:0] got, input logic [16:0] want);
        num_checks++;
        if (got !== want) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, want);
        end
    endtask
    // Apply one input set, let it settle, compare all outputs
    task go(input logic [8:0] cv, input irr_bus_irq_t bv, input irr_bus_irq_t bev, input irr_local_irq_t lev,
            input irr_bus_irq_t ep, input irr_local_irq_t el, input logic ec);
        c <= cv;
        b <= bv;
        be <= bev;
        le <= lev;
        repeat (6) @(posedge ref_clk_in);
        #1 check({bp, lp, cpu, seen}, {ep, el, ec, ec});
        n++;
        $display("test %0d done", n);
        @(posedge ref_clk_in);
    endtask
    // Verdict and end of run
    task summarize;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Main sequence
    initial begin
        {rst_in, c, b, be, le, num_errors, num_checks, n} = '0;
        rst_in = 1'b1;
        repeat (3) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        @(posedge ref_clk_in);
        go(9'h000, 11'h004, 11'h7FF, 4'h0, 11'h004, 4'h0, 1'b1);
        go(9'h028, 11'h000, 11'h7FF, 4'h0, 11'h001, 4'h4, 1'b1);
        go(9'h02A, 11'h000, 11'h7FF, 4'h0, 11'h002, 4'h4, 1'b1);
        go(9'h020, 11'h000, 11'h7FF, 4'h0, 11'h000, 4'h0, 1'b0);
        go(9'h010, 11'h000, 11'h7FF, 4'h0, 11'h000, 4'h0, 1'b0);
        go(9'h015, 11'h000, 11'h7FF, 4'h0, 11'h002, 4'h8, 1'b1);
        go(9'h100, 11'h000, 11'h000, 4'h1, 11'h000, 4'h1, 1'b1);
        go(9'h080, 11'h000, 11'h000, 4'h0, 11'h000, 4'h1, 1'b0);
        go(9'h040, 11'h000, 11'h000, 4'h2, 11'h000, 4'h2, 1'b1);
        go(9'h03C, 11'h000, 11'h7FF, 4'h0, 11'h001, 4'hC, 1'b1);
        // Mid-run reset with sources live clears every output
        rst_in <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        #1 check({bp, lp, cpu, seen}, 17'h00000);
        n++;
        $display("test %0d done", n);
        @(posedge ref_clk_in);
        rst_in <= 1'b0;
        @(posedge ref_clk_in);
        go(9'h000, 11'h400, 11'h3FF, 4'h3, 11'h400, 4'h0, 1'b0);
        summarize();
    end
endmodule // interrupt_request_input_routing_bench
